// >>> sim/rhs_host_model.sv
/*
 * Host SDIO model: clocks one read command and times the card answers.
 * Assumes pull-ups on CMD and data lines, so a released line reads high.
 */
module rhs_host_model
   import rhs_pkg::*;
(
   input  wire logic       go_i,
   input  wire logic       dev_cmd_i,
   input  wire logic       dev_cmd_oe_i,
   input  wire logic [3:0] dev_dat_i,
   input  wire logic [3:0] dev_dat_oe_i,
   output logic            clk_o,
   output logic            cmd_o,
   output logic [3:0]      dat_o,
   output logic            done_o,
   output int              resp_o,
   output int              acc_o,
   output logic [47:0]     rsp_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic        hcmd;
   logic [47:0] frame;
   int          nb;
   assign cmd_o = dev_cmd_oe_i ? dev_cmd_i : hcmd;
   assign dat_o = (dev_dat_i & dev_dat_oe_i) | ~dev_dat_oe_i;
   initial begin
      clk_o = 1'b0;
      hcmd = 1'b1;
      done_o = 1'b0;
      resp_o = 0;
      acc_o = 0;
      rsp_o = 48'h0;
      nb = 0;
      frame = {2'b01, CMD_RW_EXT, 32'h0000_0004, 8'h01};
      @(posedge go_i);
      // The clock only starts with the frame, as a real host may stop it.
      for (int i = 47; i >= 0; i--) begin
         hcmd = frame[i];
         #80 clk_o = 1'b1;
         #80 clk_o = 1'b0;
      end
      hcmd = 1'b1;
      // One command only, so spacing is kept trivially.
      // Reads only: no write data is sent and no busy is awaited.
      for (int n = 1; n <= 300; n++) begin
         #80 clk_o = 1'b1;
         if (dev_cmd_oe_i && nb < 48) begin
            rsp_o = {rsp_o[46:0], cmd_o};
            nb++;
         end
         #80 clk_o = 1'b0;
         if (resp_o == 0 && dev_cmd_oe_i) resp_o = n;
         if (acc_o == 0 && |dev_dat_oe_i) acc_o = n;
      end
      done_o = 1'b1;
   end
endmodule : rhs_host_model

// >>> sim/tb_rhs_top.sv
/*
 * Bench for the radio host control block: enables, interrupt line, bus, SDIO.
 * Assumes the host model above on the SDIO pins and a 50 cycle power-up.
 */
module tb_rhs_top
   import rhs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, rst_b, lan, sr, br, go, rd, wr, irq, rdy_b, sclk, cmd, cmd_o, cmd_oe, done, wt;
   logic [7:0]  src, addr, s8;
   logic [3:0]  dat, dat_o, dat_oe;
   logic [31:0] wd, rdata, seed;
   logic [31:0] q[$];
   logic [47:0] rsp;
   int          resp, acc, bad_count, checks_done;
   rhs_top #(.PWRUP_CYCLES(50)) rhs_top_i (.mclk_i(clk), .rst_b_i(rst_b),
      .wireless_lan_core_enable_i(lan), .short_range_core_enable_i(sr),
      .broadcast_receiver_enable_i(br), .irq_source_i(src), .wireless_interrupt_line_o(irq),
      .short_range_ready_b_o(rdy_b), .sdio_clk_i(sclk), .sdio_cmd_i(cmd), .sdio_cmd_o(cmd_o),
      .sdio_cmd_oe_o(cmd_oe), .sdio_dat_i(dat), .sdio_dat_o(dat_o), .sdio_dat_oe_o(dat_oe),
      .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
      .avs_byteenable_i(4'hf), .avs_readdata_o(rdata), .avs_waitrequest_o(wt));
   rhs_host_model rhs_host_model_i (.go_i(go), .dev_cmd_i(cmd_o), .dev_cmd_oe_i(cmd_oe),
      .dev_dat_i(dat_o), .dev_dat_oe_i(dat_oe), .clk_o(sclk), .cmd_o(cmd), .dat_o(dat),
      .done_o(done), .resp_o(resp), .acc_o(acc), .rsp_o(rsp));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic chk(string n, logic [31:0] e, logic [31:0] s);
      checks_done++;
      if (s !== e) begin
         bad_count++;
         $display("BAD %s exp %h got %h", n, e, s);
      end
   endtask : chk
   task automatic conclude();
      $display("checks %0d bad %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : conclude
   // A read notes its expected data; the monitor below compares it.
   task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      rd <= !w;
      wr <= w;
      if (!w) q.push_back(d);
      do @(posedge clk); while (wt !== 1'b0);
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus
   always @(posedge clk) begin
      if (rd === 1'b1 && wt === 1'b0 && q.size() > 0) chk("rdata", q.pop_front(), rdata);
   end
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #200000;
      bad_count++;
      conclude();
   end
   initial begin
      {rst_b, lan, sr, br, go, rd, wr} = 7'h00;
      src = 8'h00;
      addr = 8'h00;
      wd = 32'h0;
      seed = 32'd89;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      lan <= 1'b1;
      sr <= 1'b1;
      br <= 1'b0;
      repeat (40) @(posedge clk);
      chk("irq", 0, irq);
      chk("rdy", 1, rdy_b);
      repeat (20) @(posedge clk);
      chk("rdy", 0, rdy_b);
      bus(1'b1, REG_CTRL, 32'h1);
      repeat (3) @(posedge clk);
      chk("irq", 1, irq);
      s8 = 8'(rnd()) | 8'h01;
      src <= s8;
      @(posedge clk);
      src <= 8'h00;
      repeat (3) @(posedge clk);
      chk("irq", 0, irq);
      bus(1'b1, REG_IRQ_MASK, 32'h1);
      repeat (3) @(posedge clk);
      chk("irq", 1, irq);
      bus(1'b0, REG_IRQ_MASK, 32'h1);
      bus(1'b0, REG_IRQ_STATUS, {24'h0, s8});
      bus(1'b0, REG_IRQ_STATUS, 32'h0);
      bus(1'b0, 8'h20, 32'h0);
      bus(1'b1, REG_IRQ_MASK, 32'h0);
      repeat (3) @(posedge clk);
      chk("irq", 1, irq);
      go <= 1'b1;
      wait (done === 1'b1);
      chk("resp", 1, resp >= RESP_DLY_MIN && resp <= RESP_DLY_MAX);
      chk("acc", 1, acc >= 2);
      chk("resp_idx", {26'h0, CMD_RW_EXT}, {26'h0, rsp[45:40]});
      chk("resp_ends", 32'h1, {29'h0, rsp[47:46], rsp[0]});
      lan <= 1'b0;
      repeat (5) @(posedge clk);
      chk("irq", 0, irq);
      chk("rdy", 0, rdy_b);
      sr <= 1'b0;
      repeat (5) @(posedge clk);
      chk("rdy", 1, rdy_b);
      conclude();
   end
endmodule : tb_rhs_top

// >>> src/rhs_pkg.sv
/*
 * Shared constants, register map and state encoding for the radio host control block.
 * Assumes a 100 MHz system clock and an SDIO clock well below a quarter of it.
 */
package rhs_pkg;

   localparam int          CLK_HZ         = 100_000_000;
   localparam int          PWRUP_MS       = 100;
   localparam int          PWRUP_CYC      = PWRUP_MS * (CLK_HZ / 1000);

   // SDIO spacing, in SDIO clock cycles.
   localparam int          RESP_DLY_MIN   = 2;
   localparam int          RESP_DLY_MAX   = 64;
   localparam logic [10:0] RESP_DLY       = 11'h004;
   localparam logic [10:0] DATA_GAP       = 11'h002;
   localparam logic [10:0] CRC_GAP        = 11'h002;
   localparam logic [10:0] CMD_BITS       = 11'h030;
   localparam logic [10:0] CRC_NIBS       = 11'h010;
   localparam logic [10:0] TOK_BITS       = 11'h005;
   localparam logic [5:0]  CMD_RW_EXT     = 6'h35;
   localparam logic [2:0]  TOK_OK         = 3'h2;
   localparam logic [2:0]  TOK_ERR        = 3'h5;
   localparam logic [15:0] CRC16_POLY     = 16'h1021;
   localparam logic [6:0]  CRC7_POLY      = 7'h09;
   localparam int          BUF_WORDS      = 16;

   // Register byte offsets.
   localparam logic [7:0]  REG_CTRL       = 8'h00;
   localparam logic [7:0]  REG_IRQ_STATUS = 8'h04;
   localparam logic [7:0]  REG_IRQ_MASK   = 8'h08;
   localparam logic [7:0]  REG_STATE      = 8'h0c;
   localparam logic [7:0]  REG_BUF_BASE   = 8'h40;
   localparam int          CTRL_INIT_BIT  = 0;
   localparam int          MASK_BIT       = 0;
   localparam logic        CTRL_INIT_RST  = 1'b0;
   localparam logic        MASK_RST       = 1'b0;
   localparam logic [7:0]  STATUS_RST     = 8'h00;

   typedef enum logic [3:0] {
      SD_IDLE      = 4'h0,
      SD_CMD_RX    = 4'h1,
      SD_RESP_WAIT = 4'h3,
      SD_RESP_TX   = 4'h2,
      SD_RD_GAP    = 4'h6,
      SD_RD_TX     = 4'h7,
      SD_WR_WAIT   = 4'h5,
      SD_WR_RX     = 4'h4,
      SD_CRC_GAP   = 4'hc,
      SD_CRC_TX    = 4'hd
   } rhs_sdio_state_e;

endpackage : rhs_pkg

// >>> src/rhs_sync.sv
/*
 * Two flip-flop synchroniser for a group of independent level inputs.
 * Assumes each bit is a slow level or a clock far below the sampling clock.
 */
module rhs_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             mclk_i,
   input  wire logic             rst_b_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta;

   // The first stage feeds only the second stage.
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meta   <= '0;
         sync_o <= '0;
      end else begin
         meta   <= async_i;
         sync_o <= meta;
      end
   end

endmodule : rhs_sync

// >>> src/rhs_top.sv
/*
 * Core enables, power-up ready, wireless interrupt line and SDIO card cycle engine.
 * Assumes pins are asynchronous to mclk_i and an Avalon-MM master drives the registers.
 */
// Summary of operation
// - Card response 2 to 64 cycles after command
// - Read data starts at least 2 cycles late
// - CRC status exactly 2 cycles after write
// - CRC status and busy only on line 0 (no busy is driven)
// - Interrupt line low until firmware init
// - Initialised interrupt line idles high
// - Interrupt signalled by falling line
// - Masking returns the interrupt line high
// - Reading interrupt status clears it
// - LAN and short-range cores each enabled independently by own pin; broadcast enable only reported in REG_STATE
// - Ready low within 100 ms of enable
module rhs_top
   import rhs_pkg::*;
#(
   parameter int PWRUP_CYCLES = PWRUP_CYC
) (
   input  wire logic        mclk_i,
   input  wire logic        rst_b_i,
   input  wire logic        wireless_lan_core_enable_i,
   input  wire logic        short_range_core_enable_i,
   input  wire logic        broadcast_receiver_enable_i,
   input  wire logic [7:0]  irq_source_i,
   output logic             wireless_interrupt_line_o,
   output logic             short_range_ready_b_o,
   input  wire logic        sdio_clk_i,
   input  wire logic        sdio_cmd_i,
   output logic             sdio_cmd_o,
   output logic             sdio_cmd_oe_o,
   input  wire logic [3:0]  sdio_dat_i,
   output logic      [3:0]  sdio_dat_o,
   output logic      [3:0]  sdio_dat_oe_o,
   input  wire logic [7:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o
);

   function automatic logic [15:0] crc16_step(input logic [15:0] crc, input logic b);
      logic [15:0] c;
      c = {crc[14:0], 1'b0};
      if (crc[15] ^ b) begin
         c = c ^ CRC16_POLY;
      end
      return c;
   endfunction : crc16_step

   function automatic logic [6:0] crc7_of(input logic [39:0] bits);
      logic [6:0] c;
      logic       fb;
      c = 7'h00;
      for (int i = 39; i >= 0; i--) begin
         fb = c[6] ^ bits[i];
         c  = {c[5:0], 1'b0};
         if (fb) begin
            c = c ^ CRC7_POLY;
         end
      end
      return c;
   endfunction : crc7_of

   logic [8:0] sync_q;
   logic       sclk_s, cmd_s, wireless_lan_core_enable_s, sr_en_s, br_en_s;
   logic [3:0] dat_s;
   logic       sclk_d;
   logic       rise, fall;

   rhs_sync #(.WIDTH(9)) u_sync (
      .mclk_i (mclk_i),
      .rst_b_i(rst_b_i),
      .async_i({broadcast_receiver_enable_i, short_range_core_enable_i, wireless_lan_core_enable_i,
                sdio_dat_i, sdio_cmd_i, sdio_clk_i}),
      .sync_o (sync_q)
   );

   assign {br_en_s, sr_en_s, wireless_lan_core_enable_s, dat_s, cmd_s, sclk_s} = sync_q;
   assign rise = sclk_s & ~sclk_d;
   assign fall = ~sclk_s & sclk_d;

   // SDIO engine: inputs are taken on SDIO rising edges, outputs change on falling edges.
   rhs_sdio_state_e state, next_state;
   logic [10:0]     cnt, next_cnt;
   logic [47:0]     shreg, next_shreg;
   logic [63:0]     crc, next_crc;
   logic            crc_ok, next_crc_ok;
   logic [3:0]      hi_nib, next_hi_nib;
   logic            cmd_o, next_cmd_o, cmd_oe, next_cmd_oe;
   logic [3:0]      dat_o, next_dat_o, dat_oe, next_dat_oe;
   logic            sd_wr;
   logic [5:0]      sd_wr_idx;
   logic [7:0]      sd_wr_byte;
   logic [31:0]     buf_mem [BUF_WORDS];
   logic [47:0]     resp_w;
   logic [10:0]     nib_total;
   logic [10:0]     rd_k;
   logic [7:0]      rd_byte;
   logic [3:0]      rd_nib;
   logic [4:0]      tok;

   assign resp_w    = {2'b00, shreg[45:8], crc7_of({2'b00, shreg[45:8]}), 1'b1};
   assign nib_total = (shreg[16:8] == 9'h000) ? 11'h400 : {1'b0, shreg[16:8], 1'b0};
   assign rd_k      = cnt - 11'h001;
   assign rd_byte   = buf_mem[rd_k[6:3]][{rd_k[2:1], 3'b000} +: 8];
   assign rd_nib    = rd_k[0] ? rd_byte[3:0] : rd_byte[7:4];
   assign tok       = {1'b0, crc_ok ? TOK_OK : TOK_ERR, 1'b1};

   always_comb begin
      next_state  = state;
      next_cnt    = cnt;
      next_shreg  = shreg;
      next_crc    = crc;
      next_crc_ok = crc_ok;
      next_hi_nib = hi_nib;
      next_cmd_o  = cmd_o;
      next_cmd_oe = cmd_oe;
      next_dat_o  = dat_o;
      next_dat_oe = dat_oe;
      sd_wr       = 1'b0;
      sd_wr_idx   = cnt[6:1];
      sd_wr_byte  = {hi_nib, dat_s};
      if (!wireless_lan_core_enable_s) begin
         // A disabled LAN core drops every transfer and releases the bus.
         next_state  = SD_IDLE;
         next_cmd_oe = 1'b0;
         next_dat_oe = 4'h0;
         next_cmd_o  = 1'b1;
         next_dat_o  = 4'hf;
      end else begin
         unique case (state)
            SD_IDLE: begin
               if (rise && !cmd_s) begin
                  next_state = SD_CMD_RX;
                  next_shreg = {shreg[46:0], cmd_s};
                  next_cnt   = 11'h001;
               end
            end
            SD_CMD_RX: begin
               if (rise) begin
                  next_shreg = {shreg[46:0], cmd_s};
                  next_cnt   = cnt + 11'h001;
                  if (cnt == CMD_BITS - 11'h001) begin
                     next_state = SD_RESP_WAIT;
                     next_cnt   = 11'h000;
                  end
               end
            end
            SD_RESP_WAIT: begin
               if (rise) begin
                  next_cnt = cnt + 11'h001;
                  if (cnt == RESP_DLY - 11'h001) begin
                     next_state = SD_RESP_TX;
                     next_cnt   = 11'h000;
                  end
               end
            end
            SD_RESP_TX: begin
               if (fall) begin
                  if (cnt == CMD_BITS) begin
                     next_cmd_oe = 1'b0;
                     next_cmd_o  = 1'b1;
                     next_cnt    = 11'h000;
                     next_crc    = 64'h0;
                     next_crc_ok = 1'b1;
                     if (shreg[45:40] != CMD_RW_EXT) begin
                        next_state = SD_IDLE;
                     end else if (shreg[39]) begin
                        next_state = SD_WR_WAIT;
                     end else begin
                        next_state = SD_RD_GAP;
                     end
                  end else begin
                     next_cmd_oe = 1'b1;
                     next_cmd_o  = resp_w[6'(CMD_BITS - 11'h001 - cnt)];
                     next_cnt    = cnt + 11'h001;
                  end
               end
            end
            SD_RD_GAP: begin
               if (rise) begin
                  next_cnt = cnt + 11'h001;
                  if (cnt == DATA_GAP - 11'h001) begin
                     next_state = SD_RD_TX;
                     next_cnt   = 11'h000;
                  end
               end
            end
            SD_RD_TX: begin
               if (fall) begin
                  next_cnt    = cnt + 11'h001;
                  next_dat_oe = 4'hf;
                  if (cnt == 11'h000) begin
                     next_dat_o = 4'h0;
                  end else if (cnt <= nib_total) begin
                     next_dat_o = rd_nib;
                     for (int i = 0; i < 4; i++) begin
                        next_crc[16*i +: 16] = crc16_step(crc[16*i +: 16], rd_nib[i]);
                     end
                  end else if (cnt <= nib_total + CRC_NIBS) begin
                     for (int i = 0; i < 4; i++) begin
                        next_dat_o[i]        = crc[16*i + 15];
                        next_crc[16*i +: 16] = {crc[16*i +: 15], 1'b0};
                     end
                  end else if (cnt == nib_total + CRC_NIBS + 11'h001) begin
                     next_dat_o = 4'hf;
                  end else begin
                     next_dat_oe = 4'h0;
                     next_state  = SD_IDLE;
                  end
               end
            end
            SD_WR_WAIT: begin
               if (rise && !dat_s[0]) begin
                  next_state = SD_WR_RX;
                  next_cnt   = 11'h000;
               end
            end
            SD_WR_RX: begin
               if (rise) begin
                  next_cnt = cnt + 11'h001;
                  if (cnt < nib_total) begin
                     for (int i = 0; i < 4; i++) begin
                        next_crc[16*i +: 16] = crc16_step(crc[16*i +: 16], dat_s[i]);
                     end
                     if (!cnt[0]) begin
                        next_hi_nib = dat_s;
                     end else begin
                        sd_wr = 1'b1;
                     end
                  end else if (cnt < nib_total + CRC_NIBS) begin
                     for (int i = 0; i < 4; i++) begin
                        if (dat_s[i] != crc[16*i + 15]) begin
                           next_crc_ok = 1'b0;
                        end
                        next_crc[16*i +: 16] = {crc[16*i +: 15], 1'b0};
                     end
                  end else begin
                     next_state = SD_CRC_GAP;
                     next_cnt   = 11'h000;
                  end
               end
            end
            SD_CRC_GAP: begin
               if (rise) begin
                  next_cnt = cnt + 11'h001;
                  if (cnt == CRC_GAP - 11'h001) begin
                     next_state = SD_CRC_TX;
                     next_cnt   = 11'h000;
                  end
               end
            end
            SD_CRC_TX: begin
               // Busy is not signalled; the line is released right after the token.
               if (fall) begin
                  next_cnt = cnt + 11'h001;
                  if (cnt < TOK_BITS) begin
                     next_dat_oe = 4'h1;
                     next_dat_o  = {3'h7, tok[3'(TOK_BITS - 11'h001 - cnt)]};
                  end else begin
                     next_dat_oe = 4'h0;
                     next_dat_o  = 4'hf;
                     next_state  = SD_IDLE;
                  end
               end
            end
            default: begin
               next_state = SD_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sclk_d <= 1'b0;
         state  <= SD_IDLE;
         cnt    <= 11'h000;
         shreg  <= 48'h0;
         crc    <= 64'h0;
         crc_ok <= 1'b1;
         hi_nib <= 4'h0;
         cmd_o  <= 1'b1;
         cmd_oe <= 1'b0;
         dat_o  <= 4'hf;
         dat_oe <= 4'h0;
      end else begin
         sclk_d <= sclk_s;
         state  <= next_state;
         cnt    <= next_cnt;
         shreg  <= next_shreg;
         crc    <= next_crc;
         crc_ok <= next_crc_ok;
         hi_nib <= next_hi_nib;
         cmd_o  <= next_cmd_o;
         cmd_oe <= next_cmd_oe;
         dat_o  <= next_dat_o;
         dat_oe <= next_dat_oe;
      end
   end

   assign sdio_cmd_o    = cmd_o;
   assign sdio_cmd_oe_o = cmd_oe;
   assign sdio_dat_o    = dat_o;
   assign sdio_dat_oe_o = dat_oe;

   // Register slave: one wait cycle, then the access completes. A read is taken on the
   // first edge, so its data already stand when the master sees waitrequest low.
   logic        wreq, next_wreq;
   logic [31:0] rdata, next_rdata;
   logic        fw_init, next_fw_init;
   logic        mask, next_mask;
   logic [7:0]  status, next_status;
   logic        irq_line, next_irq_line;
   logic        acc, wr_acc, rd_acc, buf_hit;
   logic [3:0]  buf_idx;

   assign acc     = (avs_read_i | avs_write_i) & ~wreq;
   assign wr_acc  = acc & avs_write_i;
   assign rd_acc  = avs_read_i & wreq;
   assign buf_hit = (avs_address_i[7:6] == REG_BUF_BASE[7:6]);
   assign buf_idx = avs_address_i[5:2];

   always_comb begin
      next_wreq    = ~((avs_read_i | avs_write_i) & wreq);
      next_rdata   = rdata;
      next_fw_init = fw_init;
      next_mask    = mask;
      // A new source wins over a clear in the same cycle.
      next_status  = status | irq_source_i;
      if (rd_acc) begin
         next_rdata = 32'h0;
         if (buf_hit) begin
            next_rdata = buf_mem[buf_idx];
         end else begin
            unique case (avs_address_i)
               REG_CTRL:       next_rdata[CTRL_INIT_BIT] = fw_init;
               REG_IRQ_STATUS: begin
                  next_rdata[7:0] = status;
                  next_status     = irq_source_i;
               end
               REG_IRQ_MASK:   next_rdata[MASK_BIT] = mask;
               REG_STATE:      next_rdata[8:0] = {state, ~short_range_ready_b_o, irq_line,
                                                  br_en_s, sr_en_s, wireless_lan_core_enable_s};
               default:        next_rdata = 32'h0;
            endcase
         end
      end
      if (wr_acc && avs_byteenable_i[0]) begin
         if (avs_address_i == REG_CTRL) begin
            next_fw_init = avs_writedata_i[CTRL_INIT_BIT];
         end
         if (avs_address_i == REG_IRQ_MASK) begin
            next_mask = avs_writedata_i[MASK_BIT];
         end
      end
      if (!wireless_lan_core_enable_s) begin
         next_fw_init = CTRL_INIT_RST;
      end
      // Low until initialised, then high unless an unmasked source is pending.
      next_irq_line = fw_init & ~((|status) & ~mask);
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wreq     <= 1'b1;
         rdata    <= 32'h0;
         fw_init  <= CTRL_INIT_RST;
         mask     <= MASK_RST;
         status   <= STATUS_RST;
         irq_line <= 1'b0;
      end else begin
         wreq     <= next_wreq;
         rdata    <= next_rdata;
         fw_init  <= next_fw_init;
         mask     <= next_mask;
         status   <= next_status;
         irq_line <= next_irq_line;
      end
   end

   // Card writes take priority; software should not touch the buffer during a transfer.
   always_ff @(posedge mclk_i) begin
      if (sd_wr) begin
         buf_mem[sd_wr_idx[5:2]][{sd_wr_idx[1:0], 3'b000} +: 8] <= sd_wr_byte;
      end else if (wr_acc && buf_hit) begin
         for (int b = 0; b < 4; b++) begin
            if (avs_byteenable_i[b]) begin
               buf_mem[buf_idx][8*b +: 8] <= avs_writedata_i[8*b +: 8];
            end
         end
      end
   end

   assign avs_waitrequest_o         = wreq;
   assign avs_readdata_o            = rdata;
   assign wireless_interrupt_line_o = irq_line;

   // Short-range power-up timer, independent of the LAN core.
   logic [23:0] pu_cnt, next_pu_cnt;
   logic        rts_b, next_rts_b;

   always_comb begin
      next_pu_cnt = pu_cnt;
      next_rts_b  = rts_b;
      if (!sr_en_s) begin
         next_pu_cnt = 24'h0;
         next_rts_b  = 1'b1;
      end else if (pu_cnt == 24'(PWRUP_CYCLES - 1)) begin
         next_rts_b = 1'b0;
      end else begin
         next_pu_cnt = pu_cnt + 24'h1;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pu_cnt <= 24'h0;
         rts_b  <= 1'b1;
      end else begin
         pu_cnt <= next_pu_cnt;
         rts_b  <= next_rts_b;
      end
   end

   assign short_range_ready_b_o = rts_b;

   // Helper: SDIO rising edges since the last command end or write end.
   logic [10:0] since;
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         since <= 11'h000;
      end else if ((state == SD_CMD_RX && next_state == SD_RESP_WAIT) ||
                   (state == SD_WR_RX && next_state == SD_CRC_GAP)) begin
         since <= 11'h000;
      end else if (rise && since != 11'h7ff) begin
         since <= since + 11'h001;
      end
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);

   a_resp_delay_bound: assert property ($rose(cmd_oe) |-> since >= 11'(RESP_DLY_MIN) && since <= 11'(RESP_DLY_MAX))
      else $error("response start outside its window");
   a_read_data_late: assert property ($rose(dat_oe[3]) && state == SD_RD_TX |-> since >= DATA_GAP)
      else $error("read data too early");
   a_crc_token_gap: assert property ($rose(dat_oe[0]) && state == SD_CRC_TX |-> since == CRC_GAP)
      else $error("crc status not two cycles after write end");
   a_crc_line_zero: assert property (state == SD_CRC_TX |-> dat_oe[3:1] == 3'h0)
      else $error("crc status on a line other than zero");
   a_irq_low_uninit: assert property (!fw_init |=> !wireless_interrupt_line_o)
      else $error("interrupt line high before init");
   a_irq_idle_high: assert property (fw_init && status == 8'h00 |=> wireless_interrupt_line_o)
      else $error("idle interrupt line not high");
   a_irq_fall_cause: assert property ($fell(wireless_interrupt_line_o)
                                      |-> !$past(fw_init) || ($past(|status) && !$past(mask)))
      else $error("interrupt line fell without unmasked source");
   a_mask_line_high: assert property (fw_init && mask |=> wireless_interrupt_line_o)
      else $error("masked interrupt line not high");
   a_status_read_clr: assert property (rd_acc && avs_address_i == REG_IRQ_STATUS && irq_source_i == 8'h00
                                       |=> status == 8'h00)
      else $error("status not cleared by read");
   a_ready_after_time: assert property ($fell(short_range_ready_b_o) |-> pu_cnt == 24'(PWRUP_CYCLES - 1))
      else $error("ready asserted at wrong time");
   a_ready_needs_en: assert property (!sr_en_s |=> short_range_ready_b_o)
      else $error("ready low while core disabled");

   c_block_read:  cover property (state == SD_RD_TX && next_state == SD_IDLE);
   c_block_write: cover property (state == SD_CRC_TX && next_state == SD_IDLE);
   c_irq_fall:    cover property ($fell(wireless_interrupt_line_o));
   c_ready_low:   cover property ($fell(short_range_ready_b_o));

endmodule : rhs_top
